// ==== rtl/atoc_pkg.sv ====
/*
 * constants and carrier types for the analog threshold output block.
 * assumes a 125 MHz system clock and 32-bit word register access.
 */
package atoc_pkg;

   localparam int NCH = 8;

   // timing: sample period and clock period in ns
   localparam int CLK_PERIOD_NS = 32'h0000_0008;
   localparam int SAMPLE_PERIOD_NS = 32'h001F_C9E4;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

   // register indices; byte address is four times the index
   localparam logic [29:0] IDX_AOUT = 30'h0000_1F41;
   localparam logic [29:0] IDX_AIN = 30'h0000_2135;
   localparam logic [29:0] IDX_RANGE = 30'h0000_32D2;
   localparam logic [29:0] IDX_INVERT = 30'h0000_32DC;
   localparam logic [29:0] IDX_DOUT = 30'h0000_4651;
   localparam logic [29:0] IDX_FLEN = 30'h0000_4845;
   localparam logic [29:0] IDX_LOWER = 30'h0000_4A39;
   localparam logic [29:0] IDX_UPPER = 30'h0000_4C2D;
   localparam logic [29:0] BANK_SPAN = 30'h0000_0008;

   // full scale and reduced range scaling
   localparam logic signed [31:0] FULL_SCALE = 32'sh0098_9680;
   localparam logic signed [32:0] RANGE_DIV = 33'sh0_0000_07D0;

   // reset values
   localparam logic [31:0] RST_UPPER = 32'h7FFF_FFFF;
   localparam logic [31:0] RST_LOWER = 32'h8000_0000;
   localparam logic [15:0] RST_FLEN = 16'h0001;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;

   // per-channel threshold and filter configuration
   typedef struct packed {
      logic signed [31:0] lower;
      logic signed [31:0] upper;
      logic [15:0] flen;
   } atoc_cfg_t;

   // channel filter state
   typedef struct packed {
      logic signed [47:0] acc;
      logic [15:0] cnt;
   } atoc_filt_t;

endpackage

// ==== rtl/atoc_top.sv ====
/*
 * analog threshold output block: eight filtered analog inputs, each driving
 * one dedicated digital output through a two-setpoint hysteresis comparator,
 * plus eight analog output registers, all reached over classic wishbone.
 * assumes converter words arrive on pins asynchronously and are held stable
 * for far longer than two clocks; outputs feed pin drivers directly.
 */
`timescale 1ns/1ps

module atoc_top
   import atoc_pkg::*;
#(
   parameter int P_SAMPLE_CYCLES = SAMPLE_CYCLES
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [31:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // converter words from pins
   input wire logic [NCH-1:0][31:0] i_ain_word,
   // pin outputs
   output logic [NCH-1:0] o_dout,
   output logic [NCH-1:0][31:0] o_aout_mv
);

   function automatic logic bank_hit(input logic [29:0] idx, input logic [29:0] base);
      return (idx >= base) && (idx < base + BANK_SPAN);
   endfunction

   function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] eff_len(input logic [15:0] len);
      return (len == 16'h0000) ? 16'h0001 : len;
   endfunction

   function automatic logic signed [31:0] average(input logic signed [47:0] acc, input logic [15:0] len);
      logic signed [47:0] d;
      logic signed [47:0] q;
      d = $signed({32'h0000_0000, eff_len(len)});
      q = acc / d;
      return q[31:0];
   endfunction

   function automatic logic [31:0] rescale(input logic signed [31:0] x);
      logic signed [32:0] t;
      logic signed [32:0] q;
      t = {x[31], x} + {FULL_SCALE[31], FULL_SCALE};
      q = t / RANGE_DIV;
      return q[31:0];
   endfunction

   function automatic logic thr_next(input logic cur, input logic signed [31:0] x,
                                     input atoc_cfg_t c, input logic inv);
      if ((c.upper > FULL_SCALE) || (c.lower < -FULL_SCALE)) begin
         return cur;
      end
      if (x >= c.upper) begin
         return ~inv;
      end
      if (x < c.lower) begin
         return inv;
      end
      return cur;
   endfunction

   logic [31:0] div_cnt_ff;
   logic tick_ff;
   logic [NCH-1:0][31:0] ain_meta_ff;
   logic [NCH-1:0][31:0] ain_sync_ff;
   atoc_filt_t [NCH-1:0] filt_ff;
   logic [NCH-1:0][31:0] avg_ff;
   logic [NCH-1:0] eval_ff;
   atoc_cfg_t [NCH-1:0] cfg_ff;
   logic [NCH-1:0] invert_ff;
   logic range_ff;
   logic [NCH-1:0] dout_ff;
   logic [NCH-1:0][31:0] aout_ff;
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic [31:0] nxt_rdat;
   logic [29:0] idx;
   logic req;
   logic wr;

   assign idx = i_wb_adr[31:2];
   assign req = i_wb_cyc && i_wb_stb && !ack_ff;
   assign wr = req && i_wb_we;

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         div_cnt_ff <= RST_ZERO;
         tick_ff <= 1'b0;
      end else if (div_cnt_ff >= 32'(P_SAMPLE_CYCLES - 1)) begin
         div_cnt_ff <= RST_ZERO;
         tick_ff <= 1'b1;
      end else begin
         div_cnt_ff <= div_cnt_ff + 32'h0000_0001;
         tick_ff <= 1'b0;
      end
   end

   // pin words pass two flops
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ain_meta_ff <= '0;
         ain_sync_ff <= '0;
      end else begin
         ain_meta_ff <= i_ain_word;
         ain_sync_ff <= ain_meta_ff;
      end
   end

   // block average over the programmed length
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         filt_ff <= '0;
         avg_ff <= '0;
         eval_ff <= '0;
      end else begin
         for (int k = 0; k < NCH; k++) begin
            eval_ff[k] <= 1'b0;
            if (tick_ff) begin
               if (filt_ff[k].cnt + 16'h0001 >= eff_len(cfg_ff[k].flen)) begin
                  avg_ff[k] <= average(filt_ff[k].acc + {{16{ain_sync_ff[k][31]}}, ain_sync_ff[k]},
                                       filt_ff[k].cnt + 16'h0001);
                  filt_ff[k] <= '0;
                  eval_ff[k] <= 1'b1;
               end else begin
                  filt_ff[k].acc <= filt_ff[k].acc + {{16{ain_sync_ff[k][31]}}, ain_sync_ff[k]};
                  filt_ff[k].cnt <= filt_ff[k].cnt + 16'h0001;
               end
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         for (int k = 0; k < NCH; k++) begin
            cfg_ff[k].lower <= RST_LOWER;
            cfg_ff[k].upper <= RST_UPPER;
            cfg_ff[k].flen <= RST_FLEN;
         end
         invert_ff <= '0;
         range_ff <= 1'b0;
         aout_ff <= '0;
      end else if (wr) begin
         for (int k = 0; k < NCH; k++) begin
            if (idx == IDX_LOWER + 30'(k)) begin
               cfg_ff[k].lower <= merge_sel(cfg_ff[k].lower, i_wb_dat, i_wb_sel);
            end
            if (idx == IDX_UPPER + 30'(k)) begin
               cfg_ff[k].upper <= merge_sel(cfg_ff[k].upper, i_wb_dat, i_wb_sel);
            end
            if (idx == IDX_FLEN + 30'(k)) begin
               cfg_ff[k].flen <= 16'(merge_sel({16'h0000, cfg_ff[k].flen}, i_wb_dat, i_wb_sel));
            end
            if (idx == IDX_AOUT + 30'(k)) begin
               aout_ff[k] <= merge_sel(aout_ff[k], i_wb_dat, i_wb_sel);
            end
         end
         if (idx == IDX_INVERT && i_wb_sel[0]) begin
            invert_ff <= i_wb_dat[NCH-1:0];
         end
         if (idx == IDX_RANGE && i_wb_sel[0]) begin
            range_ff <= i_wb_dat[0];
         end
      end
   end

   // software force wins over a same-cycle evaluation
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         dout_ff <= '0;
      end else begin
         for (int k = 0; k < NCH; k++) begin
            if (wr && (idx == IDX_DOUT + 30'(k)) && i_wb_sel[0]) begin
               dout_ff[k] <= i_wb_dat[0];
            end else if (eval_ff[k]) begin
               dout_ff[k] <= thr_next(dout_ff[k], avg_ff[k], cfg_ff[k], invert_ff[k]);
            end
         end
      end
   end

   // read mux; unmapped reads give zero
   always_comb begin
      nxt_rdat = RST_ZERO;
      if (bank_hit(idx, IDX_AOUT)) begin
         nxt_rdat = aout_ff[3'(idx - IDX_AOUT)];
      end else if (bank_hit(idx, IDX_AIN)) begin
         nxt_rdat = range_ff ? rescale(avg_ff[3'(idx - IDX_AIN)]) : avg_ff[3'(idx - IDX_AIN)];
      end else if (bank_hit(idx, IDX_DOUT)) begin
         nxt_rdat = {31'h0000_0000, dout_ff[3'(idx - IDX_DOUT)]};
      end else if (bank_hit(idx, IDX_FLEN)) begin
         nxt_rdat = {16'h0000, cfg_ff[3'(idx - IDX_FLEN)].flen};
      end else if (bank_hit(idx, IDX_LOWER)) begin
         nxt_rdat = cfg_ff[3'(idx - IDX_LOWER)].lower;
      end else if (bank_hit(idx, IDX_UPPER)) begin
         nxt_rdat = cfg_ff[3'(idx - IDX_UPPER)].upper;
      end else if (idx == IDX_RANGE) begin
         nxt_rdat = {31'h0000_0000, range_ff};
      end else if (idx == IDX_INVERT) begin
         nxt_rdat = {24'h00_0000, invert_ff};
      end
   end

   // single-wait-state answer; ack drops the cycle after
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ack_ff <= 1'b0;
         rdat_ff <= RST_ZERO;
      end else begin
         ack_ff <= req;
         if (req) begin
            rdat_ff <= nxt_rdat;
         end
      end
   end

   assign o_wb_ack = ack_ff;
   assign o_wb_dat = rdat_ff;
   assign o_dout = dout_ff;
   assign o_aout_mv = aout_ff;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);

   logic ch0_dis;
   logic ch0_wr;
   assign ch0_dis = (cfg_ff[0].upper > FULL_SCALE) || (cfg_ff[0].lower < -FULL_SCALE);
   assign ch0_wr = wr && (idx == IDX_DOUT) && i_wb_sel[0];

   // channel 1 watched too, so the inverted arrangement has a live antecedent
   logic ch1_dis;
   logic ch1_wr;
   assign ch1_dis = (cfg_ff[1].upper > FULL_SCALE) || (cfg_ff[1].lower < -FULL_SCALE);
   assign ch1_wr = wr && (idx == IDX_DOUT + 30'h0000_0001) && i_wb_sel[0];

   sequence s_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence

   sequence s_answer;
      o_wb_ack ##1 !o_wb_ack;
   endsequence

   AST_BUS_ANSWER: assert property (s_req |=> s_answer)
      else $error("wishbone ack not given as a one-cycle pulse");

   AST_DOUT_READ: assert property (req && bank_hit(idx, IDX_DOUT) && !i_wb_we
                                   |=> o_wb_dat == {31'h0000_0000, $past(dout_ff[3'(idx - IDX_DOUT)])})
      else $error("output state read back wrong");

   AST_FORCE: assert property (ch0_wr |=> o_dout[0] == $past(i_wb_dat[0]))
      else $error("forced output value not applied");

   AST_AOUT_WRITE: assert property (wr && bank_hit(idx, IDX_AOUT) && (i_wb_sel == 4'hf)
                                    |=> o_aout_mv[$past(3'(idx - IDX_AOUT))] == $past(i_wb_dat))
      else $error("analog output level not taken from write");

   AST_RISE_ON: assert property (eval_ff[0] && !ch0_wr && !ch0_dis && !invert_ff[0]
                                 && $signed(avg_ff[0]) >= cfg_ff[0].upper |=> o_dout[0])
      else $error("rising mode output not on at upper setpoint");

   AST_RISE_OFF: assert property (eval_ff[0] && !ch0_wr && !ch0_dis && !invert_ff[0]
                                  && $signed(avg_ff[0]) < cfg_ff[0].lower |=> !o_dout[0])
      else $error("rising mode output not off below lower setpoint");

   AST_IN_BAND: assert property (eval_ff[0] && !ch0_wr && !ch0_dis && $signed(avg_ff[0]) >= cfg_ff[0].lower
                                 && $signed(avg_ff[0]) < cfg_ff[0].upper |=> $stable(o_dout[0]))
      else $error("output changed inside the hysteresis band");

   AST_INV_ON: assert property (eval_ff[1] && !ch1_wr && !ch1_dis && invert_ff[1]
                                && $signed(avg_ff[1]) < cfg_ff[1].lower |=> o_dout[1])
      else $error("inverted mode output not on below lower setpoint");

   AST_INV_OFF: assert property (eval_ff[1] && !ch1_wr && !ch1_dis && invert_ff[1]
                                 && $signed(avg_ff[1]) >= cfg_ff[1].upper |=> !o_dout[1])
      else $error("inverted mode output not off at upper setpoint");

   AST_DISABLED: assert property (eval_ff[0] && !ch0_wr && ch0_dis |=> $stable(o_dout[0]))
      else $error("disabled channel output changed");

   AST_HOLD: assert property (!eval_ff[0] && !ch0_wr |=> $stable(o_dout[0]))
      else $error("output changed outside an evaluation");

   AST_TICK_PERIOD: assert property (tick_ff |-> $past(div_cnt_ff) == 32'(P_SAMPLE_CYCLES - 1))
      else $error("conversion tick out of step with divider");

   AST_EVAL_AFTER_TICK: assert property (eval_ff[0] |-> $past(tick_ff))
      else $error("evaluation without a conversion");

   AST_RANGE: assert property (req && !i_wb_we && range_ff && bank_hit(idx, IDX_AIN)
                               && $signed(avg_ff[3'(idx - IDX_AIN)]) >= -FULL_SCALE
                               && $signed(avg_ff[3'(idx - IDX_AIN)]) <= FULL_SCALE
                               |=> o_wb_dat <= 32'h0000_2710)
      else $error("reduced range reading above 10000");

endmodule

// ==== tb/atoc_src_model.sv ====
/*
 * analog source model: one sensor level per channel toward the converter pins.
 * assumes the bench sets the levels; words change only after a clock edge.
 */
`timescale 1ns/1ps

module atoc_src_model
   import atoc_pkg::*;
(
   // clock
   input wire logic i_clk,
   // levels set by the bench
   input wire logic [NCH-1:0][31:0] i_level,
   // converter words
   output logic [NCH-1:0][31:0] o_ain_word
);
   // sensors settle slowly, so one edge of delay is harmless
   always_ff @(posedge i_clk) begin
      o_ain_word <= i_level;
   end
endmodule

// ==== tb/testbench.sv ====
/*
 * self-checking bench for the analog threshold output block.
 * assumes classic wishbone answers one cycle after the taken edge and a
 * shortened sample period of 20 clocks.
 */
`timescale 1ns/1ps

module testbench
   import atoc_pkg::*;
;
   localparam int SC = 20;
   typedef struct packed {
      logic [2:0] ch;
      logic [31:0] val;
      logic exp;
   } atoc_row_t;
   logic i_clk = 1'h0;
   logic i_rst_b = 1'h0;
   logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
   logic [31:0] adr = 32'h0000_0000, dat = 32'h0000_0000, o_wb_dat, q;
   logic [3:0] sel = 4'h0;
   logic o_wb_ack;
   logic [NCH-1:0][31:0] level = '0, ain, o_aout_mv;
   logic [NCH-1:0] o_dout, exp_dout = 8'h02;
   int mismatches = 0, checks_done = 0, cycles = 0;
   atoc_row_t rows [9];

   always #4 i_clk = ~i_clk;

   atoc_src_model src (.i_clk(i_clk), .i_level(level), .o_ain_word(ain));

   atoc_top #(.P_SAMPLE_CYCLES(SC)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_ain_word(ain), .o_dout(o_dout),
      .o_aout_mv(o_aout_mv));

   task summarize();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask

   // request held until ack is sampled high
   task wb(input logic wr, input logic [29:0] idx, input logic [31:0] d);
      @(posedge i_clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= wr;
      adr <= {idx, 2'h0};
      dat <= d;
      sel <= 4'hf;
      @(posedge i_clk);
      while (o_wb_ack !== 1'h1) @(posedge i_clk);
      q = o_wb_dat;
      cyc <= 1'h0;
      stb <= 1'h0;
   endtask

   task rd_chk(input logic [29:0] idx, input logic [31:0] exp);
      wb(1'h0, idx, 32'h0000_0000);
      chk(q, exp);
   endtask

   task set_in(input logic [2:0] ch, input logic [31:0] v);
      @(posedge i_clk);
      level[ch] <= v;
      repeat (3 * SC) @(posedge i_clk);
   endtask

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         summarize();
      end
   end

   initial begin
      rows = '{'{0, 32'h005B_8D80, 1}, '{0, 32'h004C_4B40, 1}, '{0, 32'h003D_0900, 1},
         '{0, 32'h003D_08FF, 0}, '{0, 32'h005B_8D7F, 0}, '{1, 32'h0000_0000, 1},
         '{1, 32'h005B_8D80, 0}, '{1, 32'h004C_4B40, 0}, '{1, 32'h003D_08FF, 1}};
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'h1;
      for (int c = 0; c < 2; c++) begin
         wb(1'h1, IDX_LOWER + 30'(c), 32'h003D_0900);
         wb(1'h1, IDX_UPPER + 30'(c), 32'h005B_8D80);
      end
      wb(1'h1, IDX_INVERT, 32'h0000_0002);
      // one sensor moves per row; every other output must hold
      foreach (rows[i]) begin
         set_in(rows[i].ch, rows[i].val);
         exp_dout[rows[i].ch] = rows[i].exp;
         chk(32'(o_dout), 32'(exp_dout));
         rd_chk(IDX_DOUT + 30'(rows[i].ch), 32'(rows[i].exp));
         rd_chk(IDX_AIN + 30'(rows[i].ch), rows[i].val);
      end
      $display("threshold rows done");
      // upper beyond full scale: forced on, input far below lower
      wb(1'h1, IDX_UPPER, 32'h0098_9681);
      wb(1'h1, IDX_DOUT, 32'h0000_0001);
      @(posedge i_clk);
      chk(32'(o_dout[0]), 32'h1);
      set_in(0, 32'h0000_0000);
      chk(32'(o_dout[0]), 32'h1);
      // lower beyond minus full scale: forced off, input at top
      wb(1'h1, IDX_UPPER, 32'h005B_8D80);
      wb(1'h1, IDX_LOWER, 32'hFF67_697F);
      wb(1'h1, IDX_DOUT, 32'h0000_0000);
      @(posedge i_clk);
      chk(32'(o_dout[0]), 32'h0);
      set_in(0, FULL_SCALE);
      chk(32'(o_dout[0]), 32'h0);
      wb(1'h1, IDX_LOWER, 32'h003D_0900);
      repeat (3 * SC) @(posedge i_clk);
      chk(32'(o_dout[0]), 32'h1);
      $display("disable and force done");
      wb(1'h1, IDX_RANGE, 32'h0000_0001);
      set_in(3, 32'h001E_8480);
      rd_chk(IDX_AIN + 30'h3, 32'h0000_1770);
      wb(1'h1, IDX_RANGE, 32'h0000_0000);
      // readings bank ignores writes
      wb(1'h1, IDX_AIN + 30'h3, 32'h0000_0055);
      rd_chk(IDX_AIN + 30'h3, 32'h001E_8480);
      wb(1'h1, IDX_AOUT + 30'h5, 32'h0000_1194);
      @(posedge i_clk);
      chk(o_aout_mv[5], 32'h0000_1194);
      rd_chk(IDX_AOUT + 30'h5, 32'h0000_1194);
      rd_chk(30'h0000_0010, 32'h0000_0000);
      // two-sample block average on channel 2, negative input
      wb(1'h1, IDX_FLEN + 30'h2, 32'h0000_0002);
      rd_chk(IDX_FLEN + 30'h2, 32'h0000_0002);
      set_in(2, 32'hFFE1_7B80);
      repeat (3 * SC) @(posedge i_clk);
      rd_chk(IDX_AIN + 30'h2, 32'hFFE1_7B80);
      $display("range, outputs and map done");
      // second reset in mid-run
      @(posedge i_clk);
      i_rst_b <= 1'h0;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'h1;
      @(posedge i_clk);
      chk(32'(o_dout), 32'h0000_0000);
      chk(o_aout_mv[5], 32'h0000_0000);
      rd_chk(IDX_UPPER, RST_UPPER);
      rd_chk(IDX_LOWER + 30'h7, RST_LOWER);
      rd_chk(IDX_FLEN + 30'h2, 32'(RST_FLEN));
      rd_chk(IDX_RANGE, 32'h0000_0000);
      $display("reset values done");
      summarize();
   end
endmodule
